// ### hw/ecl_pkg.sv
/*
  Package for the event and configuration logger: register offsets,
  field positions, reset values, log depths and the packed carriers.
  Assumes an APB master with 32-bit data and byte addresses.
*/
`default_nettype none
package ecl_pkg;

  // ----------------------------------------------------------------
  // depths and widths
  // ----------------------------------------------------------------
  localparam int unsigned INFO_DEPTH = 50;
  localparam int unsigned CFG_DEPTH  = 25;
  localparam int unsigned AW         = 8;
  localparam logic [5:0]  INFO_DEPTH_V = 6'h32;
  localparam logic [5:0]  CFG_DEPTH_V  = 6'h19;
  localparam logic [5:0]  HOURS_DAY    = 6'h18;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] A_CTRL      = 8'h00;
  localparam logic [7:0] A_INFO_MASK = 8'h04;
  localparam logic [7:0] A_STATUS    = 8'h08;
  localparam logic [7:0] A_EVT_CNT   = 8'h0C;
  localparam logic [7:0] A_INFO_IDX  = 8'h10;
  localparam logic [7:0] A_INFO_W0   = 8'h14;
  localparam logic [7:0] A_INFO_W4   = 8'h24;
  localparam logic [7:0] A_CFG_IDX   = 8'h28;
  localparam logic [7:0] A_CFG_W0    = 8'h2C;
  localparam logic [7:0] A_CFG_W6    = 8'h44;
  localparam logic [7:0] A_TARIFF    = 8'h48;
  localparam logic [7:0] A_MM_TIME   = 8'h4C;
  localparam logic [7:0] A_MM_DATE   = 8'h50;
  localparam logic [7:0] A_IRQ_STAT  = 8'h54;
  localparam logic [7:0] A_IRQ_MASK  = 8'h58;

  // ----------------------------------------------------------------
  // fields and reset values
  // ----------------------------------------------------------------
  localparam int unsigned CTRL_DST_EN   = 0;
  localparam int unsigned CTRL_TS_APPLY = 1;
  localparam int unsigned CTRL_RULE_LO  = 2;
  localparam int unsigned IRQ_INFO      = 0;
  localparam int unsigned IRQ_CFG       = 1;
  localparam int unsigned IRQ_REFUSED   = 2;
  localparam int unsigned IRQ_TRANSPORT = 3;
  localparam logic [3:0]  CTRL_RST      = 4'h5;
  localparam logic [15:0] INFO_MASK_RST = 16'hFFFF;
  localparam logic [12:0] TARIFF_RST    = 13'h1600;
  localparam logic [3:0]  SUMMER_FIRST  = 4'h4;
  localparam logic [3:0]  SUMMER_LAST   = 4'hA;

  typedef enum logic [1:0] {
    ECL_RULE_NONE = 2'b00,
    ECL_RULE_CAL  = 2'b01,
    ECL_RULE_EXT  = 2'b10
  } ecl_rule_t;

  typedef struct packed {
    logic [6:0] yy;
    logic [3:0] mo;
    logic [4:0] dd;
  } ecl_date_t;

  typedef struct packed {
    logic [4:0] hh;
    logic [5:0] mi;
    logic [5:0] ss;
  } ecl_time_t;

  typedef struct packed {
    ecl_date_t date;
    ecl_time_t tim;
  } ecl_stamp_t;

  typedef struct packed {
    logic [31:0] heat;
    logic [31:0] cool;
    logic [31:0] vol;
    logic [31:0] hours;
    logic [7:0]  toffs;
    logic [15:0] num;
  } ecl_totals_t;

  typedef struct packed {
    ecl_stamp_t  st;
    logic        dst;
    logic [15:0] code;
    logic [31:0] heat;
    logic [31:0] cool;
  } ecl_info_ent_t;

  typedef struct packed {
    ecl_stamp_t  st;
    logic        dst;
    ecl_totals_t tot;
  } ecl_cfg_ent_t;

endpackage : ecl_pkg
`default_nettype wire

// ### hw/ecl_sync.sv
/*
  Two-flop synchroniser for pin levels.
  Assumes inputs are slow levels; no pulse is narrower than a clock.
*/
`timescale 1ns/100ps
`default_nettype none
module ecl_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_r;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_r <= '0;
      q      <= '0;
    end
    else
    begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule : ecl_sync
`default_nettype wire

// ### hw/ecl_logger.sv
/*
  Info and config event logger with daylight-saving handling, APB slave.
  Assumes time stamp, totals, info code and event pulses come from logic
  on pclk; only the housing-separation level arrives from a pin.
*/
// The implementer's own choices: the address map and register access over APB.
// Notes on behaviour
// - info code change logs stamp, code, energies
// - keep latest 50 entries, all readable
// - only country-enabled code bits raise events
// - event bumps counter and writes log entry
// - no count or log in transport/separated
// - mask changes never alter stored entries
// - config entry holds stamp, number, totals, offset
// - max 25 config changes until total reset
// - leaving setup menu writes config entry unless the 25-entry log is full
// - country rule selects daylight-saving set
// - stamps stored standard time plus offset flag
// - disabled daylight saving drops offset on read
// - tariff window follows local time
// - tariff energy never touched by toggling
// - scheduled tick at standard-time midnight
// - max/min stamp stored standard, read local
// - read-out separate offset or applied offset
// - transport until first integration, entered again by total reset
`timescale 1ns/100ps
`default_nettype none
module ecl_logger (
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [7:0]          paddr,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire ecl_pkg::ecl_stamp_t now_std,
  input  wire ecl_pkg::ecl_totals_t totals,
  input  wire logic [15:0]         info_code,
  input  wire logic                dst_ext_summer,
  input  wire logic                cfg_change,
  input  wire logic                setup_enter,
  input  wire logic                setup_leave,
  input  wire logic                first_integ,
  input  wire logic                total_reset,
  input  wire logic                maxmin_capture,
  input  wire logic                top_sep_pin,
  output logic                     irq,
  output logic                     transport_state,
  output logic                     cfg_locked,
  output logic                     tariff_active,
  output logic                     sched_log_tick
);
  import ecl_pkg::*;

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  // newest-first index into a ring; idx is clamped below depth
  function automatic logic [5:0] ecl_slot(input logic [5:0] ptr,
                                         input logic [5:0] idx,
                                         input logic [5:0] depth);
    logic [6:0] s;
    s = {1'b0, ptr} + {1'b0, depth} - 7'h01 - {1'b0, idx};
    if (s >= {1'b0, depth})
      s = s - {1'b0, depth};
    return s[5:0];
  endfunction : ecl_slot

  function automatic logic [4:0] ecl_hour(input logic [4:0] hh,
                                         input logic off);
    logic [5:0] h;
    h = {1'b0, hh} + {5'h00, off};
    if (h >= HOURS_DAY)
      h = h - HOURS_DAY;
    return h[4:0];
  endfunction : ecl_hour

  // stored standard time, formatted per current enable and mode
  function automatic logic [31:0] ecl_fmt(input ecl_time_t t,
                                         input logic dst,
                                         input logic en,
                                         input logic apply);
    logic off;
    off = dst & en;
    if (apply)
      return {11'h000, ecl_hour(t.hh, off), 2'h0, t.mi, 2'h0, t.ss};
    return {7'h00, off, 3'h0, t.hh, 2'h0, t.mi, 2'h0, t.ss};
  endfunction : ecl_fmt

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [3:0]    ctrl_r;
  logic [15:0]   mask_r;
  logic [15:0]   code_prev_r;
  logic [31:0]   evt_cnt_r;
  logic [5:0]    info_ptr_r;
  logic [5:0]    info_fill_r;
  logic [5:0]    info_idx_r;
  logic [5:0]    cfg_cnt_r;
  logic [5:0]    cfg_idx_r;
  logic          setup_seen_r;
  logic          transport_r;
  logic [12:0]   tariff_r;
  logic [3:0]    irq_stat_r;
  logic [3:0]    irq_mask_r;
  logic [5:0]    ss_prev_r;
  ecl_stamp_t    mm_st_r;
  logic          mm_dst_r;
  ecl_info_ent_t info_mem [INFO_DEPTH];
  ecl_cfg_ent_t  cfg_mem [CFG_DEPTH];
  logic          top_sep;

  ecl_sync #(.W(1)) u_sep_sync (
    .clk   (pclk),
    .rst_n (presetn),
    .d     (top_sep_pin),
    .q     (top_sep)
  );

  // ----------------------------------------------------------------
  // daylight saving and tariff
  // ----------------------------------------------------------------
  wire ecl_rule_t rule = ecl_rule_t'(ctrl_r[CTRL_RULE_LO +: 2]);
  wire dst_en    = ctrl_r[CTRL_DST_EN];
  wire ts_apply  = ctrl_r[CTRL_TS_APPLY];
  wire cal_hit   = (now_std.date.mo >= SUMMER_FIRST) &&
                   (now_std.date.mo <= SUMMER_LAST);
  wire rule_hit  = (rule == ECL_RULE_CAL) ? cal_hit :
                   (rule == ECL_RULE_EXT) ? dst_ext_summer : 1'b0;
  wire summer    = dst_en & rule_hit;
  wire [4:0] local_hh = ecl_hour(now_std.tim.hh, summer);
  wire [4:0] tar_lo   = tariff_r[4:0];
  wire [4:0] tar_hi   = tariff_r[12:8];
  // only a window flag is produced; accumulated energy lives elsewhere
  wire tar_in = (tar_lo <= tar_hi) ?
                ((local_hh >= tar_lo) && (local_hh < tar_hi)) :
                ((local_hh >= tar_lo) || (local_hh < tar_hi));
  wire new_sec  = now_std.tim.ss != ss_prev_r;
  // standard midnight reads as local 01.00 while summer time applies
  wire midnight = new_sec && (now_std.tim.hh == 5'h00) &&
                  (now_std.tim.mi == 6'h00) && (now_std.tim.ss == 6'h00);

  // ----------------------------------------------------------------
  // event qualification
  // ----------------------------------------------------------------
  wire [15:0] code_diff = (info_code ^ code_prev_r) & mask_r;
  wire blocked   = transport_r | top_sep;
  wire info_evt  = (|code_diff) & ~blocked & ~total_reset;
  wire cfg_req   = cfg_change | (setup_leave & setup_seen_r);
  wire full_cfg  = cfg_cnt_r == CFG_DEPTH_V;
  wire cfg_wr    = cfg_req & ~full_cfg & ~total_reset;
  wire cfg_ref   = cfg_req & full_cfg & ~total_reset;
  wire trans_end = transport_r & first_integ & ~total_reset;

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  wire acc  = psel & penable;
  wire done = acc & pready;
  wire wr   = done & pwrite;
  wire in_info = (paddr >= A_INFO_W0) && (paddr <= A_INFO_W4);
  wire in_cfg  = (paddr >= A_CFG_W0) && (paddr <= A_CFG_W6);
  wire [7:0] info_off = paddr - A_INFO_W0;
  wire [7:0] cfg_off  = paddr - A_CFG_W0;
  wire [5:0] info_sl  = ecl_slot(info_ptr_r, info_idx_r, INFO_DEPTH_V);
  wire [5:0] cfg_sl   = ecl_slot(cfg_cnt_r, cfg_idx_r, CFG_DEPTH_V);
  wire ecl_info_ent_t ie = info_mem[info_sl];
  wire ecl_cfg_ent_t  ce = cfg_mem[cfg_sl[4:0]];
  wire hit = (paddr[1:0] == 2'b00) &&
             (paddr <= A_IRQ_MASK);
  wire [3:0] irq_set = {trans_end, cfg_ref, cfg_wr, info_evt};
  wire [3:0] irq_clr = (wr && paddr == A_IRQ_STAT) ? pwdata[3:0] : 4'h0;
  wire [5:0] idx_w   = pwdata[5:0];

  logic [31:0] info_word;
  logic [31:0] cfg_word;
  logic [31:0] rd_word;

  always_comb
  begin
    case (info_off[4:2])
      3'h0:    info_word = {16'h0000, ie.st.date};
      3'h1:    info_word = ecl_fmt(ie.st.tim, ie.dst, dst_en, ts_apply);
      3'h2:    info_word = {16'h0000, ie.code};
      3'h3:    info_word = ie.heat;
      3'h4:    info_word = ie.cool;
      default: info_word = 32'h0000_0000;
    endcase
    case (cfg_off[4:2])
      3'h0:    cfg_word = {16'h0000, ce.st.date};
      3'h1:    cfg_word = ecl_fmt(ce.st.tim, ce.dst, dst_en, ts_apply) &
                          32'hFFFF_FFC0;
      3'h2:    cfg_word = {8'h00, ce.tot.toffs, ce.tot.num};
      3'h3:    cfg_word = ce.tot.heat;
      3'h4:    cfg_word = ce.tot.cool;
      3'h5:    cfg_word = ce.tot.vol;
      3'h6:    cfg_word = ce.tot.hours;
      default: cfg_word = 32'h0000_0000;
    endcase
    if (in_info)
      rd_word = info_word;
    else if (in_cfg)
      rd_word = cfg_word;
    else
    begin
      case (paddr)
        A_CTRL:      rd_word = {28'h0000000, ctrl_r};
        A_INFO_MASK: rd_word = {16'h0000, mask_r};
        A_STATUS:    rd_word = {10'h000, info_fill_r, 2'h0, cfg_cnt_r,
                                4'h0, summer, full_cfg, top_sep, transport_r};
        A_EVT_CNT:   rd_word = evt_cnt_r;
        A_INFO_IDX:  rd_word = {26'h0000000, info_idx_r};
        A_CFG_IDX:   rd_word = {26'h0000000, cfg_idx_r};
        A_TARIFF:    rd_word = {19'h00000, tariff_r};
        A_MM_TIME:   rd_word = ecl_fmt(mm_st_r.tim, mm_dst_r,
                                       dst_en, ts_apply);
        A_MM_DATE:   rd_word = {16'h0000, mm_st_r.date};
        A_IRQ_STAT:  rd_word = {28'h0000000, irq_stat_r};
        A_IRQ_MASK:  rd_word = {28'h0000000, irq_mask_r};
        default:     rd_word = 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // apb response: one wait state, data from flops
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else
    begin
      pready  <= acc & ~pready;
      pslverr <= acc & ~pready & ~hit;
      if (acc & ~pready)
        prdata <= hit ? rd_word : 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // software registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_r     <= CTRL_RST;
      mask_r     <= INFO_MASK_RST;
      info_idx_r <= 6'h00;
      cfg_idx_r  <= 6'h00;
      tariff_r   <= TARIFF_RST;
      irq_mask_r <= 4'h0;
      irq_stat_r <= 4'h0;
    end
    else
    begin
      if (wr && paddr == A_CTRL)
        ctrl_r <= pwdata[3:0];
      if (wr && paddr == A_INFO_MASK)
        mask_r <= pwdata[15:0];
      if (wr && paddr == A_INFO_IDX)
        info_idx_r <= (idx_w < INFO_DEPTH_V) ? idx_w : INFO_DEPTH_V - 6'h01;
      if (wr && paddr == A_CFG_IDX)
        cfg_idx_r <= (idx_w < CFG_DEPTH_V) ? idx_w : CFG_DEPTH_V - 6'h01;
      if (wr && paddr == A_TARIFF)
        tariff_r <= pwdata[12:0];
      if (wr && paddr == A_IRQ_MASK)
        irq_mask_r <= pwdata[3:0];
      // set wins over a same-cycle clear
      irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_set;
    end
  end

  // ----------------------------------------------------------------
  // event state
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      code_prev_r     <= 16'h0000;
      evt_cnt_r       <= 32'h0000_0000;
      info_ptr_r      <= 6'h00;
      info_fill_r     <= 6'h00;
      cfg_cnt_r       <= 6'h00;
      setup_seen_r    <= 1'b0;
      transport_r     <= 1'b1;
      ss_prev_r       <= 6'h00;
      mm_st_r         <= '0;
      mm_dst_r        <= 1'b0;
      irq             <= 1'b0;
      transport_state <= 1'b1;
      cfg_locked      <= 1'b0;
      tariff_active   <= 1'b0;
      sched_log_tick  <= 1'b0;
    end
    else
    begin
      // tracked always, so blocked changes never fire later
      code_prev_r <= info_code;
      ss_prev_r   <= now_std.tim.ss;
      if (info_evt)
      begin
        evt_cnt_r  <= evt_cnt_r + 32'h0000_0001;
        info_ptr_r <= (info_ptr_r == INFO_DEPTH_V - 6'h01) ?
                      6'h00 : info_ptr_r + 6'h01;
        if (info_fill_r != INFO_DEPTH_V)
          info_fill_r <= info_fill_r + 6'h01;
      end
      if (total_reset)
      begin
        cfg_cnt_r   <= 6'h00;
        transport_r <= 1'b1;
      end
      else
      begin
        if (cfg_wr)
          cfg_cnt_r <= cfg_cnt_r + 6'h01;
        if (first_integ)
          transport_r <= 1'b0;
      end
      if (setup_enter)
        setup_seen_r <= 1'b1;
      else if (setup_leave)
        setup_seen_r <= 1'b0;
      if (maxmin_capture)
      begin
        mm_st_r  <= now_std;
        mm_dst_r <= rule_hit;
      end
      irq             <= |((irq_stat_r & ~irq_clr | irq_set) & irq_mask_r);
      transport_state <= total_reset | (transport_r & ~first_integ);
      cfg_locked      <= ~total_reset & ((cfg_cnt_r + {5'h00, cfg_wr})
                         == CFG_DEPTH_V);
      tariff_active   <= tar_in;
      sched_log_tick  <= midnight;
    end
  end

  // ----------------------------------------------------------------
  // log storage, no reset: reads are not gated, STATUS fill and count show valid entries
  // ----------------------------------------------------------------
  always_ff @(posedge pclk)
  begin
    if (info_evt)
      info_mem[info_ptr_r] <= '{st: now_std, dst: rule_hit,
                                code: info_code, heat: totals.heat,
                                cool: totals.cool};
    if (cfg_wr)
      cfg_mem[cfg_cnt_r[4:0]] <= '{st: now_std, dst: rule_hit,
                                   tot: totals};
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_evt_count;
    info_evt |=> evt_cnt_r == $past(evt_cnt_r) + 32'h0000_0001;
  endproperty
  a_evt_count: assert property (p_evt_count) else $error("counter miss");

  property p_blocked;
    (transport_r || top_sep) |-> !info_evt;
  endproperty
  a_blocked: assert property (p_blocked) else $error("event blocked");

  property p_enabled_bits;
    info_evt |-> ((info_code ^ code_prev_r) & mask_r) != 16'h0000;
  endproperty
  a_enabled_bits: assert property (p_enabled_bits) else $error("mask");

  property p_cfg_limit;
    cfg_cnt_r == CFG_DEPTH_V && !total_reset |=> cfg_cnt_r == CFG_DEPTH_V;
  endproperty
  a_cfg_limit: assert property (p_cfg_limit) else $error("cfg limit");

  property p_ring_full;
    info_fill_r == INFO_DEPTH_V |=> info_fill_r == INFO_DEPTH_V;
  endproperty
  a_ring_full: assert property (p_ring_full) else $error("ring");

  property p_transport_end;
    (!transport_r && !total_reset) ##1 !total_reset
      |=> !transport_r && !transport_state;
  endproperty
  a_transport_end: assert property (p_transport_end) else $error("trans");

  property p_setup_log;
    setup_leave && setup_seen_r && !full_cfg && !total_reset
      |=> cfg_cnt_r == $past(cfg_cnt_r) + 6'h01;
  endproperty
  a_setup_log: assert property (p_setup_log) else $error("setup log");

  property p_ptr_wrap;
    info_evt && info_ptr_r == INFO_DEPTH_V - 6'h01 |=> info_ptr_r == 6'h00;
  endproperty
  a_ptr_wrap: assert property (p_ptr_wrap) else $error("ptr wrap");

  property p_tariff;
    presetn && tar_in |=> tariff_active;
  endproperty
  a_tariff: assert property (p_tariff) else $error("tariff");

  c_info_wrap: cover property (info_evt && info_fill_r == INFO_DEPTH_V);
  c_cfg_refused: cover property (cfg_ref);
  c_trans_end: cover property (trans_end ##[1:20] info_evt);
endmodule : ecl_logger
`default_nettype wire

// ### verification/ecl_tb.sv
/*
  Self-checking bench for the event and configuration logger.
  Assumes the logger's APB slave, pulse inputs and ecl_pkg.
*/
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import ecl_pkg::*;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic        pclk, presetn, psel, penable, pwrite, sep, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, irq, trs, lck, ext, tar, tick;
  logic [15:0] code;
  logic [5:0]  pul;
  ecl_stamp_t  now;
  ecl_totals_t tot;
  int          bad_count, checked;

  ecl_logger ecl_logger_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .now_std(now), .totals(tot),
    .info_code(code), .dst_ext_summer(ext), .cfg_change(pul[0]),
    .setup_enter(pul[1]), .setup_leave(pul[2]), .first_integ(pul[3]),
    .total_reset(pul[4]), .maxmin_capture(pul[5]), .top_sep_pin(sep),
    .irq(irq), .transport_state(trs), .cfg_locked(lck),
    .tariff_active(tar), .sched_log_tick(tick)
  );

  initial
  begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic tally_and_finish();
    $display("checked %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    for (n = 0; n < 16; n++)
    begin
      @(posedge pclk);
      if (pready === 1'h1)
        break;
    end
    // a missing answer ends the run rather than hanging it
    if (n >= 16)
    begin
      bad_count++;
      tally_and_finish();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb

  task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string m);
    apb(1'h0, a, 32'h0);
    chk(rd, e, m);
  endtask : rchk

  task automatic pulse(input int b);
    @(posedge pclk);
    pul[b] <= 1'h1;
    @(posedge pclk);
    pul <= 6'h0;
    repeat (2) @(posedge pclk);
  endtask : pulse

  task automatic setcode(input logic [15:0] c);
    @(posedge pclk);
    code <= c;
    repeat (2) @(posedge pclk);
  endtask : setcode

  function automatic logic [31:0] tw(input logic f, input logic [4:0] h);
    return {7'h0, f, 3'h0, h, 2'h0, now.tim.mi, 2'h0, now.tim.ss};
  endfunction : tw
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    chk(trs, 1'h1, "transport after reset");
    rchk(A_CTRL, CTRL_RST, "ctrl reset");
    rchk(A_INFO_MASK, INFO_MASK_RST, "mask reset");
    rchk(A_TARIFF, TARIFF_RST, "tariff reset");
    rchk(A_IRQ_MASK, 32'h0, "irq mask reset");
    chk(tar, 1'h1, "winter tariff window");
    apb(1'h0, 8'h5C, 32'h0);
    chk(err, 1'h1, "unmapped read error");
  endtask : t_reset

  task automatic t_transport();
    setcode(16'h0001);
    rchk(A_EVT_CNT, 32'h0, "count in transport");
    apb(1'h1, A_IRQ_MASK, 32'h9);
    pulse(3);
    chk(trs, 1'h0, "transport left");
    chk(irq, 1'h1, "transport irq");
    apb(1'h1, A_IRQ_STAT, 32'hF);
  endtask : t_transport

  task automatic t_info();
    setcode(16'h0003);
    rchk(A_EVT_CNT, 32'h1, "event count");
    chk(irq, 1'h1, "info irq");
    rchk(A_INFO_W0 + 8'h8, 32'h3, "logged code");
    rchk(A_INFO_W0 + 8'hC, tot.heat, "logged heat");
    rchk(A_INFO_W0 + 8'h10, tot.cool, "logged cool");
    rchk(A_INFO_W0 + 8'h4, tw(1'h0, 5'h0A), "winter stamp");
    apb(1'h1, A_IRQ_STAT, 32'h1);
    repeat (2) @(posedge pclk);
    chk(irq, 1'h0, "irq cleared");
    // disabled bits 1 and 2: no event, old entry untouched
    apb(1'h1, A_INFO_MASK, 32'hFFF9);
    setcode(16'h0001);
    rchk(A_EVT_CNT, 32'h1, "masked bit counted");
    rchk(A_INFO_W0 + 8'h8, 32'h3, "entry altered");
    apb(1'h1, A_INFO_MASK, 32'hFFFF);
    @(posedge pclk);
    sep <= 1'h1;
    repeat (4) @(posedge pclk);
    setcode(16'h0005);
    rchk(A_EVT_CNT, 32'h1, "count while separated");
    sep <= 1'h0;
    repeat (4) @(posedge pclk);
  endtask : t_info

  task automatic t_dst();
    @(posedge pclk);
    now.date.mo <= 4'h6;
    setcode(16'h0007);
    rchk(A_EVT_CNT, 32'h2, "count after rejoin");
    rchk(A_INFO_W0 + 8'h4, tw(1'h1, 5'h0A), "summer stamp");
    pulse(5);
    rchk(A_MM_TIME, tw(1'h1, 5'h0A), "max/min stamp");
    apb(1'h1, A_TARIFF, 32'h0B0A);
    repeat (2) @(posedge pclk);
    chk(tar, 1'h0, "summer tariff window");
    apb(1'h1, A_CTRL, 32'h7);
    rchk(A_INFO_W0 + 8'h4, tw(1'h0, 5'h0B), "applied offset");
    apb(1'h1, A_CTRL, 32'h6);
    rchk(A_INFO_W0 + 8'h4, tw(1'h0, 5'h0A), "offset dropped");
    chk(tar, 1'h1, "standard tariff window");
    apb(1'h1, A_CTRL, 32'h9);
    apb(1'h0, A_STATUS, 32'h0);
    chk(rd[3], 1'h0, "external rule, winter");
    ext <= 1'h1;
    apb(1'h0, A_STATUS, 32'h0);
    chk(rd[3], 1'h1, "external rule, summer");
    ext <= 1'h0;
    apb(1'h1, A_CTRL, 32'h5);
  endtask : t_dst

  task automatic t_tick();
    @(posedge pclk);
    now.tim <= {5'h17, 6'h00, 6'h00};
    @(posedge pclk);
    @(negedge pclk);
    chk(tick, 1'h0, "tick at local midnight");
    @(posedge pclk);
    now.tim <= {5'h17, 6'h3B, 6'h3B};
    @(posedge pclk);
    now.tim <= {5'h00, 6'h00, 6'h00};
    @(posedge pclk);
    @(negedge pclk);
    chk(tick, 1'h1, "tick at standard midnight");
    @(negedge pclk);
    chk(tick, 1'h0, "tick is one pulse");
  endtask : t_tick

  task automatic t_cfg();
    pulse(1);
    pulse(2);
    apb(1'h0, A_STATUS, 32'h0);
    chk(rd[13:8], 6'h01, "menu entry logged");
    rchk(A_CFG_W0 + 8'h8, {8'h0, tot.toffs, tot.num}, "cfg number");
    rchk(A_CFG_W0 + 8'h18, tot.hours, "cfg hours");
    repeat (24) pulse(0);
    chk(lck, 1'h1, "locked at limit");
    pulse(0);
    apb(1'h0, A_IRQ_STAT, 32'h0);
    chk(rd[2], 1'h1, "refused flag");
    pulse(4);
    chk(lck, 1'h0, "unlocked by reset");
    chk(trs, 1'h1, "transport again");
  endtask : t_cfg

  initial
  begin
    presetn = 1'h0;
    {psel, penable, pwrite, sep, ext} = 5'h00;
    paddr = 8'h0;
    pwdata = 32'h0;
    pul = 6'h0;
    code = 16'h0;
    bad_count = 0;
    checked = 0;
    now = {7'h18, 4'h1, 5'h01, 5'h0A, 6'h1E, 6'h05};
    tot = {32'h11, 32'h22, 32'h33, 32'h44, 8'h55, 16'h0066};
    repeat (3) @(posedge pclk);
    presetn <= 1'h1;
    t_reset();
    t_transport();
    t_info();
    t_dst();
    t_tick();
    t_cfg();
    tally_and_finish();
  end
endmodule : testbench
`default_nettype wire
